/* logic/adcp_params.svh */
// Register map, field positions, reset values and timing counts of the converter block
`ifndef ADCP_PARAMS_SVH
`define ADCP_PARAMS_SVH

// ==================================================
// Register byte addresses
`define ADCP_ADDR_RESULT 8'h00
`define ADCP_ADDR_DATA   8'h04
`define ADCP_ADDR_CTL    8'h08
`define ADCP_ADDR_PCFG   8'h0c
`define ADCP_ADDR_DIR    8'h10
`define ADCP_ADDR_STATUS 8'h14
`define ADCP_ADDR_MASK   8'h18

// ==================================================
// Control register and reference select field positions
`define ADCP_CTL_CLK_HI  7
`define ADCP_CTL_CLK_LO  6
`define ADCP_CTL_CHAN_HI 4
`define ADCP_CTL_CHAN_LO 3
`define ADCP_CTL_GO      2
`define ADCP_CTL_FLAG    1
`define ADCP_CTL_ON      0
`define ADCP_PCFG_VREF   4

// ==================================================
// Reset values and codes
`define ADCP_DIR_RST     5'h1f
`define ADCP_PCFG_RST    5'h00
`define ADCP_CLK_OSC2    2'h0
`define ADCP_CLK_OSC8    2'h1
`define ADCP_CLK_OSC32   2'h2
`define ADCP_CLK_RC      2'h3
`define ADCP_RESP_OKAY   2'h0
`define ADCP_RESP_SLVERR 2'h2

// ==================================================
// Timing
`define ADCP_CLK_PERIOD_NS 40
`define ADCP_RC_PERIOD_NS  2000
`define ADCP_RC_DIV        (`ADCP_RC_PERIOD_NS / `ADCP_CLK_PERIOD_NS)
`define ADCP_DIV_OSC2      6'h02
`define ADCP_DIV_OSC8      6'h08
`define ADCP_DIV_OSC32     6'h20
`define ADCP_SAMPLE_LAST   2'h1
`define ADCP_BIT_LAST      2'h2

`endif

/* logic/adcp_pkg.sv */
// Types shared by the converter control modules
package adcp_pkg;

  typedef logic [7:0] adcp_byte_t;

  // ==================================================
  // Successive approximation sequencer
  typedef enum {SAR_IDLE, SAR_SAMPLE, SAR_BITS} adcp_sar_st_t;

  typedef struct packed {
    adcp_sar_st_t st;
    logic [5:0]   div;
    logic         tick;
    logic [1:0]   phase;
    logic [2:0]   bitn;
    adcp_byte_t   sar;
    adcp_byte_t   trial;
    logic         sh;
    logic         busy;
    logic         done;
    adcp_byte_t   result;
  } adcp_sar_t;

  // ==================================================
  // Register file and bus slave
  typedef struct packed {
    logic        awready, wready, arready, bvalid, rvalid;
    logic        aw_full, w_full, wstb;
    logic [1:0]  bresp, rresp;
    logic [7:0]  awaddr;
    adcp_byte_t  wdata;
    logic [31:0] rdata;
    logic [1:0]  clk_sel, chan;
    logic        go, flag, power, start;
    adcp_byte_t  result;
    logic [4:0]  pcfg, dir, latch, pin_oe;
    logic        irq_st, irq_mask, irq;
  } adcp_top_t;

endpackage

/* logic/adcp_conv_if.sv */
// Link between the register file and the conversion sequencer
interface adcp_conv_if;
  import adcp_pkg::*;
  logic       start;
  logic       power;
  logic       sleep;
  logic       cmp;
  logic [1:0] clk_sel;
  logic       busy;
  logic       done;
  adcp_byte_t result;

  modport ctl  (output start, power, sleep, cmp, clk_sel, input busy, done, result);
  modport core (input start, power, sleep, cmp, clk_sel, output busy, done, result);
endinterface

/* logic/adcp_sync.sv */
// Three-stage input synchroniser that passes a change once stages two and three agree
module adcp_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1, s2, s3, q;
  } adcp_sync_t;

  adcp_sync_t r;
  adcp_sync_t next_r;

  // Shift chain; only stage two reads stage one
  always_comb begin
    next_r    = r;
    next_r.s1 = async_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.q[i] = r.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sync_out = r.q;
endmodule

/* logic/adcp_sar.sv */
// Successive approximation sequencer with conversion clock divider
`include "adcp_params.svh"
module adcp_sar (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  adcp_conv_if.core          cif,
  output adcp_pkg::adcp_byte_t dac_code,
  output logic               sample_hold
);
  import adcp_pkg::*;

  adcp_sar_t  r;
  adcp_sar_t  next_r;
  logic [5:0] lim;
  logic       run;
  adcp_byte_t kept;

  // Divider terminal count per clock choice
  always_comb begin
    case (cif.clk_sel)
      `ADCP_CLK_OSC2:  lim = `ADCP_DIV_OSC2;
      `ADCP_CLK_OSC8:  lim = `ADCP_DIV_OSC8;
      `ADCP_CLK_OSC32: lim = `ADCP_DIV_OSC32;
      default:         lim = 6'(`ADCP_RC_DIV);
    endcase
  end

  // Only the internal RC choice keeps ticking in sleep
  assign run = cif.power && (r.st != SAR_IDLE) &&
               !(cif.sleep && (cif.clk_sel != `ADCP_CLK_RC));

  // Sequencer: sample, then eight trial bits from the top down
  always_comb begin
    next_r      = r;
    next_r.done = 1'h0;
    next_r.tick = 1'h0;
    kept        = cif.cmp ? r.trial : r.sar;
    if (run) begin
      if (r.div >= lim - 6'h01) begin
        next_r.div  = 6'h00;
        next_r.tick = 1'h1;
      end else begin
        next_r.div = r.div + 6'h01;
      end
    end
    case (r.st)
      SAR_IDLE: begin
        next_r.div = 6'h00;
        if (cif.start && cif.power) begin
          next_r.st    = SAR_SAMPLE;
          next_r.sh    = 1'h1;
          next_r.busy  = 1'h1;
          next_r.phase = 2'h0;
        end
      end
      SAR_SAMPLE: begin
        if (r.tick) begin
          if (r.phase == `ADCP_SAMPLE_LAST) begin
            next_r.sh    = 1'h0;
            next_r.st    = SAR_BITS;
            next_r.bitn  = 3'h7;
            next_r.sar   = 8'h00;
            next_r.trial = 8'h80;
            next_r.phase = 2'h0;
          end else begin
            next_r.phase = r.phase + 2'h1;
          end
        end
      end
      SAR_BITS: begin
        if (r.tick) begin
          if (r.phase == `ADCP_BIT_LAST) begin
            next_r.phase = 2'h0;
            if (r.bitn == 3'h0) begin
              next_r.result = kept;
              next_r.done   = 1'h1;
              next_r.busy   = 1'h0;
              next_r.trial  = 8'h00;
              next_r.st     = SAR_IDLE;
            end else begin
              next_r.sar   = kept;
              next_r.bitn  = r.bitn - 3'h1;
              next_r.trial = kept | (8'h01 << (r.bitn - 3'h1));
            end
          end else begin
            next_r.phase = r.phase + 2'h1;
          end
        end
      end
      default: next_r.st = SAR_IDLE;
    endcase
    // Power off shuts the core down at once
    if (!cif.power) begin
      next_r.st    = SAR_IDLE;
      next_r.busy  = 1'h0;
      next_r.sh    = 1'h0;
      next_r.trial = 8'h00;
      next_r.div   = 6'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign dac_code    = r.trial;
  assign sample_hold = r.sh;
  assign cif.busy    = r.busy;
  assign cif.done    = r.done;
  assign cif.result  = r.result;

  // ==================================================
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic osc2_ok;
  assign osc2_ok = cif.power && !cif.sleep && (cif.clk_sel == `ADCP_CLK_OSC2) &&
                   (r.st != SAR_IDLE);

  sequence osc2_run_s;
    (r.tick && osc2_ok) ##1 osc2_ok;
  endsequence

  osc2_rate_a: assert property (osc2_run_s |-> ##1 r.tick)
    else $error("divide-by-two tick missed");
  sleep_hold_a: assert property (
    (cif.sleep && cif.clk_sel != `ADCP_CLK_RC) |=> !r.tick)
    else $error("tick while asleep on a non-RC clock");
  hold_busy_a: assert property (r.sh |-> (r.busy && r.st == SAR_SAMPLE))
    else $error("sample-hold open outside sampling");
  done_idle_a: assert property (r.done |-> (!r.busy && r.st == SAR_IDLE))
    else $error("done pulse while still converting");
endmodule

/* logic/adcp_top.sv */
// Converter control and shared pin group: register file, bus slave, pins, interrupt
//
// The AXI4-Lite interface to the registers was left to the implementer.
`include "adcp_params.svh"
module adcp_top (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic [4:0]      pin_in,
  output logic [4:0]           pin_out,
  output logic [4:0]           pin_oe,
  input  wire logic            cmp_in,
  input  wire logic            sleep,
  output adcp_pkg::adcp_byte_t dac_code,
  output logic                 sample_hold,
  output logic [1:0]           channel_select,
  output logic                 vref_external,
  output logic                 converter_power,
  output logic                 irq
);
  import adcp_pkg::*;

  adcp_top_t  r;
  adcp_top_t  next_r;
  logic [5:0] sync_all;
  logic [4:0] pin_rd;
  logic       wr_fire;
  logic       rd_fire;

  // ==================================================
  // Input synchronisers and the conversion core
  adcp_sync #(.W(6)) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({cmp_in, pin_in}),
    .sync_out (sync_all)
  );

  adcp_conv_if cif ();

  // Request side of the core link
  assign cif.start   = r.start;
  assign cif.power   = r.power;
  assign cif.sleep   = sleep;
  assign cif.cmp     = sync_all[5];
  assign cif.clk_sel = r.clk_sel;

  adcp_sar u_sar (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .cif         (cif.core),
    .dac_code    (dac_code),
    .sample_hold (sample_hold)
  );

  // ==================================================
  // Pin read path: analog pins and the reference pin read as zero
  assign pin_rd = {sync_all[4],
                   sync_all[3:0] & r.pcfg[3:0] & ~{r.pcfg[`ADCP_PCFG_VREF], 3'h0}};

  // Bus handshakes
  assign wr_fire = r.aw_full && r.w_full && !r.bvalid;
  assign rd_fire = s_axi_arvalid && r.arready;

  // Address decode for both directions
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      `ADCP_ADDR_RESULT, `ADCP_ADDR_DATA, `ADCP_ADDR_CTL, `ADCP_ADDR_PCFG,
      `ADCP_ADDR_DIR, `ADCP_ADDR_STATUS, `ADCP_ADDR_MASK: mapped = 1'h1;
      default: mapped = 1'h0;
    endcase
  endfunction

  // Read data mux
  function automatic logic [31:0] rd_value(input logic [7:0] a);
    case (a)
      `ADCP_ADDR_RESULT: rd_value = {24'h0, r.result};
      `ADCP_ADDR_DATA:   rd_value = {27'h0, pin_rd};
      `ADCP_ADDR_CTL:    rd_value = {24'h0, r.clk_sel, 1'h0, r.chan, r.go, r.flag, r.power};
      `ADCP_ADDR_PCFG:   rd_value = {27'h0, r.pcfg};
      `ADCP_ADDR_DIR:    rd_value = {27'h0, r.dir};
      `ADCP_ADDR_STATUS: rd_value = {31'h0, r.irq_st};
      `ADCP_ADDR_MASK:   rd_value = {31'h0, r.irq_mask};
      default:           rd_value = 32'h0;
    endcase
  endfunction

  // ==================================================
  // Next-state logic for bus slave, registers and interrupt
  always_comb begin
    next_r       = r;
    next_r.start = 1'h0;
    // Write address and data are taken independently
    if (s_axi_awvalid && r.awready) begin
      next_r.awaddr  = s_axi_awaddr;
      next_r.aw_full = 1'h1;
      next_r.awready = 1'h0;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.wdata  = s_axi_wdata[7:0];
      next_r.wstb   = s_axi_wstrb[0];
      next_r.w_full = 1'h1;
      next_r.wready = 1'h0;
    end
    // Register write once both halves are held
    if (wr_fire) begin
      next_r.aw_full = 1'h0;
      next_r.w_full  = 1'h0;
      next_r.bvalid  = 1'h1;
      next_r.bresp   = mapped(r.awaddr) ? `ADCP_RESP_OKAY : `ADCP_RESP_SLVERR;
      if (r.awaddr == `ADCP_ADDR_DATA) begin
        // Unwritten lane keeps the pin levels just read
        next_r.latch = r.wstb ? r.wdata[4:0] : pin_rd;
      end else if (r.wstb) begin
        case (r.awaddr)
          `ADCP_ADDR_CTL: begin
            next_r.clk_sel = r.wdata[`ADCP_CTL_CLK_HI:`ADCP_CTL_CLK_LO];
            next_r.chan    = r.wdata[`ADCP_CTL_CHAN_HI:`ADCP_CTL_CHAN_LO];
            next_r.flag    = r.wdata[`ADCP_CTL_FLAG];
            next_r.power   = r.wdata[`ADCP_CTL_ON];
            if (r.wdata[`ADCP_CTL_GO] && r.wdata[`ADCP_CTL_ON] && !r.go) begin
              next_r.go    = 1'h1;
              next_r.start = 1'h1;
            end
          end
          `ADCP_ADDR_PCFG: next_r.pcfg     = r.wdata[4:0];
          `ADCP_ADDR_DIR:  next_r.dir      = r.wdata[4:0];
          `ADCP_ADDR_MASK: next_r.irq_mask = r.wdata[0];
          default: ;
        endcase
      end
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid  = 1'h0;
      next_r.awready = 1'h1;
      next_r.wready  = 1'h1;
    end
    // Reads answer at the edge that takes the address
    if (rd_fire) begin
      next_r.arready = 1'h0;
      next_r.rvalid  = 1'h1;
      next_r.rdata   = rd_value(s_axi_araddr);
      next_r.rresp   = mapped(s_axi_araddr) ? `ADCP_RESP_OKAY : `ADCP_RESP_SLVERR;
      if (s_axi_araddr == `ADCP_ADDR_STATUS) begin
        next_r.irq_st = 1'h0;
      end
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid  = 1'h0;
      next_r.arready = 1'h1;
    end
    // Completion comes last so its set wins over any clear
    if (cif.done) begin
      next_r.result = cif.result;
      next_r.go     = 1'h0;
      next_r.flag   = 1'h1;
      next_r.irq_st = 1'h1;
    end
    if (!next_r.power) begin
      next_r.go = 1'h0;
    end
    // Driver follows direction even in analog mode
    next_r.pin_oe = ~next_r.dir;
    next_r.irq    = next_r.irq_st & next_r.irq_mask;
  end

  // State register with reset values
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r         <= '0;
      r.awready <= 1'h1;
      r.wready  <= 1'h1;
      r.arready <= 1'h1;
      r.dir     <= `ADCP_DIR_RST;
      r.pcfg    <= `ADCP_PCFG_RST;
      r.pin_oe  <= 5'h00;
    end else begin
      r <= next_r;
    end
  end

  // ==================================================
  // Outputs, all from flip-flops
  assign s_axi_awready   = r.awready;
  assign s_axi_wready    = r.wready;
  assign s_axi_bresp     = r.bresp;
  assign s_axi_bvalid    = r.bvalid;
  assign s_axi_arready   = r.arready;
  assign s_axi_rdata     = r.rdata;
  assign s_axi_rresp     = r.rresp;
  assign s_axi_rvalid    = r.rvalid;
  assign pin_out         = r.latch;
  assign pin_oe          = r.pin_oe;
  assign channel_select  = r.chan;
  assign vref_external   = r.pcfg[`ADCP_PCFG_VREF];
  assign converter_power = r.power;
  assign irq             = r.irq;

  // ==================================================
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence ctl_wr_s;
    wr_fire && r.wstb && (r.awaddr == `ADCP_ADDR_CTL);
  endsequence

  done_load_a: assert property (cif.done |=>
    (r.result == $past(cif.result)) && !r.go && r.flag)
    else $error("completion did not load result, clear go and set flag");
  start_power_a: assert property (r.start |-> (r.power && r.go))
    else $error("start issued with converter off");
  go_busy_a: assert property (r.start |=> ##1 cif.busy)
    else $error("go set but core not busy");
  power_abort_a: assert property ($fell(r.power) |-> ##[1:2] !cif.busy)
    else $error("core still busy after power off");
  chan_route_a: assert property (ctl_wr_s |=>
    (channel_select == $past(r.wdata[4:3])) && (r.clk_sel == $past(r.wdata[7:6])))
    else $error("channel or clock field not applied");
  vref_sel_a: assert property (
    (wr_fire && r.wstb && r.awaddr == `ADCP_ADDR_PCFG) |=> vref_external == $past(r.wdata[4]))
    else $error("reference choice not applied");
  analog_zero_a: assert property (
    (rd_fire && s_axi_araddr == `ADCP_ADDR_DATA && r.pcfg[3:0] == 4'h0)
    |=> r.rdata[3:0] == 4'h0)
    else $error("analog pin read as nonzero");
  dir_drive_a: assert property (
    (wr_fire && r.wstb && r.awaddr == `ADCP_ADDR_DIR) |=> pin_oe == ~$past(r.wdata[4:0]))
    else $error("driver enable does not follow direction");
  latch_rmw_a: assert property (
    (wr_fire && !r.wstb && r.awaddr == `ADCP_ADDR_DATA) |=> pin_out == $past(pin_rd))
    else $error("masked port write did not store pin levels");
  latch_write_a: assert property (
    (wr_fire && r.wstb && r.awaddr == `ADCP_ADDR_DATA) |=> pin_out == $past(r.wdata[4:0]))
    else $error("port write did not reach latch");

  // ==================================================
  // Checks on the done flag, result, go bit and event status
  flag_sticky_a: assert property (
    (r.flag && !(wr_fire && r.wstb && r.awaddr == `ADCP_ADDR_CTL)) |=> r.flag)
    else $error("completion flag cleared without a software write");
  result_hold_a: assert property (!cif.done |=> $stable(r.result))
    else $error("result changed outside completion");
  go_rise_a: assert property ($rose(r.go) |-> r.start)
    else $error("go bit set without a start request");
  power_go_a: assert property (!r.power |-> !r.go)
    else $error("go bit set while converter off");
  // A done in the same cycle must win over the read clear
  status_clear_a: assert property (
    (rd_fire && s_axi_araddr == `ADCP_ADDR_STATUS && !cif.done) |=> !r.irq_st)
    else $error("status read did not clear the event bit");
  status_set_a: assert property (cif.done |=> r.irq_st)
    else $error("completion did not set the event bit");

  // ==================================================
  // Bus answers stand until the master takes them
  sequence b_wait_s;
    s_axi_bvalid && !s_axi_bready;
  endsequence

  sequence r_wait_s;
    s_axi_rvalid && !s_axi_rready;
  endsequence

  b_hold_a: assert property (b_wait_s |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");
  r_hold_a: assert property (r_wait_s |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed before it was taken");
  // Only one write and one read may be under way
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels open while a response waits");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while read data waits");
endmodule

/* sim/adcp_analog.sv */
// Analog side model: four input channels, sample-hold, comparator and pin levels
module adcp_analog #(
  parameter int VREF = 128
) (
  input  wire logic        ref_clk,
  input  wire logic [31:0] levels,
  input  wire logic [4:0]  ext_pins,
  input  wire logic [7:0]  dac_code,
  input  wire logic        sample_hold,
  input  wire logic [1:0]  channel_select,
  input  wire logic        vref_external,
  input  wire logic        converter_power,
  input  wire logic [4:0]  pin_out,
  input  wire logic [4:0]  pin_oe,
  output logic             cmp_in,
  output logic [4:0]       pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] held = 8'h00;
  logic       junk = 1'b0;
  int         v;

  // One shared hold stage follows the selected channel while sampling
  always @(posedge ref_clk) begin
    junk <= ~junk;
    if (sample_hold) begin
      v = int'(levels[8 * channel_select +: 8]);
      if (vref_external) begin
        v = v * 255 / VREF;
      end
      held <= (v > 255) ? 8'hff : v[7:0];
    end
  end

  // Comparator is meaningless while unpowered, so it wanders
  assign cmp_in = converter_power ? (held >= dac_code) : junk;
  // Driven pins show the latch, floating pins show the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_pins);
endmodule

/* sim/test_adc_control_port_a.sv */
// Self-checking bench for the converter control and pin group block
`include "adcp_params.svh"
module test_adc_control_port_a;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int VREF = 128;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        sleep = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [4:0]  ext = 5'h0f;
  logic [31:0] levels = 32'h0;
  logic [7:0]  seed = 8'h3f;
  logic        awready, wready, bvalid, arready, rvalid, cmp_in, sample_hold;
  logic        vref_external, converter_power, irq;
  logic [1:0]  bresp, rresp, channel_select;
  logic [31:0] rdata;
  logic [4:0]  pin_in, pin_out, pin_oe;
  adcp_pkg::adcp_byte_t dac_code;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          checked = 0;
  int          miscompares = 0;

  adcp_top adcp_top_inst (
    .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .cmp_in(cmp_in),
    .sleep(sleep), .dac_code(dac_code), .sample_hold(sample_hold),
    .channel_select(channel_select), .vref_external(vref_external),
    .converter_power(converter_power), .irq(irq)
  );

  adcp_analog #(.VREF(VREF)) adcp_analog_inst (
    .ref_clk(ref_clk), .levels(levels), .ext_pins(ext), .dac_code(dac_code),
    .sample_hold(sample_hold), .channel_select(channel_select),
    .vref_external(vref_external), .converter_power(converter_power),
    .pin_out(pin_out), .pin_oe(pin_oe), .cmp_in(cmp_in), .pin_in(pin_in)
  );

  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  // ==================================================
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Result expected for a level under the chosen reference
  function automatic logic [7:0] eff(input logic [7:0] lv, input logic x);
    int t;
    t = x ? int'(lv) * 255 / VREF : int'(lv);
    return (t > 255) ? 8'hff : t[7:0];
  endfunction

  function automatic logic [33:0] ok(input logic [7:0] v);
    return {2'h0, 24'h0, v};
  endfunction

  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic stall();
    miscompares++;
    $display("Error wait expected answer seen none");
    test_done();
  endtask

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic ck_irq(input logic e);
    @(posedge ref_clk);
    chk("irq", 34'(e), 34'(irq));
  endtask

  // ==================================================
  // Bus master tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s,
                    input logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= {3'h0, s};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    if (n >= 100) stall();
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    n = 0;
    @(posedge ref_clk);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    if (n >= 100) stall();
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 2000) stall();
  endtask

  // Each answer is compared with the oldest noted expectation
  always @(posedge ref_clk) begin
    if (bvalid && bready) chk("bresp", 34'(bq.pop_front()), 34'(bresp));
    if (rvalid && rready) chk("rdata", rq.pop_front(), {rresp, rdata});
  end

  // ==================================================
  // Main sequence
  initial begin
    logic [7:0]  ctl;
    logic [31:0] lv;
    logic        x;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    // Reset values and an unmapped place
    rd(`ADCP_ADDR_RESULT, ok(8'h00));
    rd(`ADCP_ADDR_CTL, ok(8'h00));
    rd(`ADCP_ADDR_PCFG, ok(8'h00));
    rd(`ADCP_ADDR_DIR, ok(8'h1f));
    rd(`ADCP_ADDR_DATA, ok(8'h00));
    rd(8'h1c, {2'h2, 32'h0});
    wr(8'h1c, 8'hff, 1'b1, 2'h2);
    // Digital pins: two outputs, three inputs at random levels
    seed = lfsr(seed);
    ext <= seed[4:0];
    wr(`ADCP_ADDR_PCFG, 8'h0f, 1'b1, 2'h0);
    wr(`ADCP_ADDR_DIR, 8'h1c, 1'b1, 2'h0);
    wr(`ADCP_ADDR_DATA, 8'h1a, 1'b1, 2'h0);
    chk("pin_oe", 34'(5'h03), 34'(pin_oe));
    chk("pin_out", 34'(5'h1a), 34'(pin_out));
    repeat (6) @(posedge ref_clk);
    rd(`ADCP_ADDR_DATA, ok({3'h0, ext[4:2], 2'b10}));
    wr(`ADCP_ADDR_DATA, 8'h00, 1'b0, 2'h0);
    chk("pin_out", 34'({ext[4:2], 2'b10}), 34'(pin_out));
    wr(`ADCP_ADDR_DIR, 8'h1f, 1'b1, 2'h0);
    wr(`ADCP_ADDR_MASK, 8'h01, 1'b1, 2'h0);
    // One conversion per clock code and channel
    for (int i = 0; i < 4; i++) begin
      repeat (4) begin
        seed = lfsr(seed);
        lv = {lv[23:0], seed};
      end
      levels <= lv;
      x = (i == 1);
      ctl = {i[1:0], 1'b0, i[1:0], 3'b101};
      sleep <= (i >= 2);
      wr(`ADCP_ADDR_PCFG, {3'h0, x, 4'h0}, 1'b1, 2'h0);
      wr(`ADCP_ADDR_CTL, ctl, 1'b1, 2'h0);
      rd(`ADCP_ADDR_CTL, ok(ctl));
      chk("channel_select", 34'(i[1:0]), 34'(channel_select));
      chk("vref_external", 34'(x), 34'(vref_external));
      if (i == 2) begin
        repeat (1000) @(posedge ref_clk);
        ck_irq(1'b0);
        sleep <= 1'b0;
      end
      wait_irq();
      sleep <= 1'b0;
      rd(`ADCP_ADDR_RESULT, ok(eff(lv[8 * i +: 8], x)));
      rd(`ADCP_ADDR_CTL, ok(ctl & 8'hfb | 8'h02));
      wr(`ADCP_ADDR_MASK, 8'h00, 1'b1, 2'h0);
      ck_irq(1'b0);
      wr(`ADCP_ADDR_MASK, 8'h01, 1'b1, 2'h0);
      ck_irq(1'b1);
      rd(`ADCP_ADDR_STATUS, ok(8'h01));
      ck_irq(1'b0);
      rd(`ADCP_ADDR_STATUS, ok(8'h00));
    end
    // Power off in mid-conversion aborts it
    wr(`ADCP_ADDR_CTL, 8'hc5, 1'b1, 2'h0);
    chk("converter_power", 34'(1'b1), 34'(converter_power));
    wr(`ADCP_ADDR_CTL, 8'hc0, 1'b1, 2'h0);
    repeat (3) @(posedge ref_clk);
    chk("converter_power", 34'(1'b0), 34'(converter_power));
    rd(`ADCP_ADDR_CTL, ok(8'hc0));
    repeat (1500) @(posedge ref_clk);
    ck_irq(1'b0);
    test_done();
  end
endmodule
